// >>> hdl/fcctl_copy.v
// Purpose: copies one internal routine from routine rom into on-chip ram
// Assumes: rom data one cycle after rom_rd
// Notes:   abort stops the copy at once, no done pulse
`timescale 1ns/1ps
`include "fcctl_defines.vh"

module fcctl_copy (
   // clock and reset
   input  wire        core_clk,
   input  wire        sys_rst,
   // control
   input  wire        start,
   input  wire        abort,
   input  wire        sel_erase,
   input  wire [7:0]  dest,
   output wire        busy,
   output wire        done,
   // routine rom
   output wire        rom_rd,
   output wire        rom_sel_erase,
   output wire [7:0]  rom_addr,
   input  wire [15:0] rom_data,
   // on-chip ram
   output wire        ram_wr,
   output wire [15:0] ram_addr,
   output wire [15:0] ram_wdata
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_RUN   = 2'h1;
   localparam ST_DRAIN = 2'h2;

   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg  [7:0]  idx_ff;
   reg  [7:0]  rd_idx_ff;
   reg         rd_vld_ff;
   reg         sel_ff;
   reg  [7:0]  dest_ff;
   reg         wr_ff;
   reg  [15:0] waddr_ff;
   reg  [15:0] wdata_ff;
   reg         done_ff;

   // =====================================================================
   // sequencer
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (idx_ff == `FCCTL_ROUTINE_LAST) begin
               nxt_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!rd_vld_ff && !wr_ff) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (abort) begin
         nxt_state = ST_IDLE;
      end
   end

   // =====================================================================
   // datapath
   always @(posedge core_clk) begin
      if (sys_rst || abort) begin
         state_ff  <= ST_IDLE;
         idx_ff    <= `FCCTL_BYTE_ZERO;
         rd_idx_ff <= `FCCTL_BYTE_ZERO;
         rd_vld_ff <= 1'b0;
         sel_ff    <= 1'b0;
         dest_ff   <= `FCCTL_BYTE_ZERO;
         wr_ff     <= 1'b0;
         waddr_ff  <= `FCCTL_WORD_ZERO;
         wdata_ff  <= `FCCTL_WORD_ZERO;
         done_ff   <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         rd_vld_ff <= (state_ff == ST_RUN);
         rd_idx_ff <= idx_ff;
         wr_ff     <= rd_vld_ff;
         done_ff   <= rd_vld_ff && (rd_idx_ff == `FCCTL_ROUTINE_LAST);
         if (rd_vld_ff) begin
            waddr_ff <= {dest_ff, rd_idx_ff};
            wdata_ff <= rom_data;
         end
         if (state_ff == ST_IDLE && start) begin
            idx_ff  <= `FCCTL_BYTE_ZERO;
            sel_ff  <= sel_erase;
            dest_ff <= dest;
         end else if (state_ff == ST_RUN) begin
            idx_ff <= idx_ff + 8'h01;
         end
      end
   end

   assign rom_rd        = (state_ff == ST_RUN);
   assign rom_sel_erase = sel_ff;
   assign rom_addr      = idx_ff;
   assign ram_wr        = wr_ff;
   assign ram_addr      = waddr_ff;
   assign ram_wdata     = wdata_ff;
   assign busy          = (state_ff != ST_IDLE);
   assign done          = done_ff;

endmodule // fcctl_copy

// >>> hdl/fcctl_sync.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: asynchronous level input
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ps

module fcctl_sync (
   // clock and reset
   input  wire core_clk,
   input  wire sys_rst,
   // level in and out
   input  wire async_in,
   output wire sync_out
);

   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   reg out_ff;

   // =====================================================================
   // stages
   always @(posedge core_clk) begin
      if (sys_rst) begin
         s1_ff  <= 1'b0;
         s2_ff  <= 1'b0;
         s3_ff  <= 1'b0;
         out_ff <= 1'b0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            out_ff <= s3_ff;
         end
      end
   end

   assign sync_out = out_ff;

endmodule // fcctl_sync

// >>> hdl/fcctl_top.v
// Purpose: flash code control and status register with routine download
// Assumes: fault and mode inputs on core_clk, hardware standby from a pin
// Notes:   sys_rst acts as the power-on reset
//          fault set beats a same-cycle standby clear
//          standby and watch entry abort a running copy
//          interrupt set beats a same-cycle clear write
//
// Summary of operation
// - flash fault sets the fault flag at bit 4; set flag forces error protection
// - fault flag at 0 means normal operation, error protection off
// - fault flag cleared only by power-on reset or hardware standby entry
// - software standby and watch entry leave the fault flag unchanged
// - reserved bits 3 to 1 read 0; software writes 0 there
// - accepted download request copies selected routine to ram at destination
// - download request accepted only while key holds a5
// - download request accepted only when written from on-chip ram
// - download request accepted only with ram emulation select at 0
// - download request clears on completion; it never reads as 1
`timescale 1ns/1ps
`include "fcctl_defines.vh"

module fcctl_top (
   // clock and reset
   input  wire        core_clk,
   input  wire        sys_rst,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output wire [7:0]  reg_rdata,
   // flash macro and mode inputs
   input  wire        flash_fault_event,
   input  wire        hw_standby_pin,
   input  wire        sw_standby_entry,
   input  wire        watch_entry,
   // sibling register values
   input  wire [7:0]  unlock_key_register,
   input  wire        program_routine_select,
   input  wire        erase_routine_select,
   input  wire [7:0]  download_destination,
   input  wire        ram_emulation_select,
   input  wire        exec_from_ram,
   // routine rom
   output wire        rom_rd,
   output wire        rom_sel_erase,
   output wire [7:0]  rom_addr,
   input  wire [15:0] rom_data,
   // on-chip ram
   output wire        ram_wr,
   output wire [15:0] ram_addr,
   output wire [15:0] ram_wdata,
   // status outputs
   output wire        error_protect,
   output wire        download_busy,
   output wire        download_done,
   output wire        irq
);

   // =====================================================================
   // declarations
   // standby
   wire                    hw_standby;
   reg                     hw_standby_d_ff;
   wire                    hw_standby_entry;
   wire                    soft_init;

   // fault flag
   wire                    fault_raise;
   wire                    fault_clear;
   reg                     fault_ff;
   reg                     nxt_fault;

   // interrupts
   reg  [`FCCTL_IRQ_W-1:0] irq_stat_ff;
   reg  [`FCCTL_IRQ_W-1:0] nxt_irq_stat;
   reg  [`FCCTL_IRQ_W-1:0] irq_en_ff;
   reg  [`FCCTL_IRQ_W-1:0] irq_set;
   reg  [`FCCTL_IRQ_W-1:0] irq_clr;
   wire                    ev_fault;
   wire                    ev_done;
   wire                    ev_refuse;
   wire                    wr_irq_en;
   wire                    wr_irq_clr;

   // download
   wire                    wr_ctrl;
   wire                    req_write;
   wire                    gate_ok;
   wire                    routine_ok;
   wire                    engine_free;
   wire                    mode_idle;
   wire                    dl_start;
   wire                    dl_refused;
   wire                    copy_busy;
   wire                    copy_done;
   wire                    sel_erase;

   // read data
   reg  [7:0]              rdata_ff;
   reg  [7:0]              nxt_rdata;
   wire                    key_ok;
   wire [7:0]              ctrl_img;
   wire [7:0]              irq_stat_img;
   wire [7:0]              irq_en_img;
   wire [7:0]              dl_stat_img;

   // =====================================================================
   // functions
   function gates_met;
      input [7:0] key;
      input       in_ram;
      input       emul;
      begin
         gates_met = (key == `FCCTL_UNLOCK_KEY) && in_ram && !emul;
      end
   endfunction

   function [7:0] ctrl_image;
      input fault;
      reg   [7:0] v;
      begin
         v                   = `FCCTL_CTRL_FIXED;
         v[`FCCTL_BIT_FAULT] = fault;
         v[`FCCTL_BIT_REQ]   = 1'b0;
         ctrl_image          = v;
      end
   endfunction

   function wr_hit;
      input       wr;
      input [7:0] addr;
      input [7:0] target;
      begin
         wr_hit = wr && (addr == target);
      end
   endfunction

   function erase_pick;
      input prog;
      input erase;
      begin
         erase_pick = !prog && erase;
      end
   endfunction

   function [7:0] pad_irq;
      input [`FCCTL_IRQ_W-1:0] bits;
      reg   [7:0]              v;
      begin
         v                   = `FCCTL_BYTE_ZERO;
         v[`FCCTL_IRQ_W-1:0] = bits;
         pad_irq             = v;
      end
   endfunction

   function [7:0] dl_image;
      input       busy;
      input       key_good;
      input       in_ram;
      input       emul;
      input       erase;
      reg   [7:0] v;
      begin
         v                    = `FCCTL_BYTE_ZERO;
         v[`FCCTL_DL_BUSY]    = busy;
         v[`FCCTL_DL_KEY_OK]  = key_good;
         v[`FCCTL_DL_IN_RAM]  = in_ram;
         v[`FCCTL_DL_NO_EMUL] = !emul;
         v[`FCCTL_DL_ERASE]   = erase;
         dl_image             = v;
      end
   endfunction

   // =====================================================================
   // hardware standby synchroniser
   fcctl_sync u_hw_standby_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (hw_standby_pin),
      .sync_out (hw_standby)
   );

   always @(posedge core_clk) begin
      if (sys_rst) begin
         hw_standby_d_ff <= 1'b0;
      end else begin
         hw_standby_d_ff <= hw_standby;
      end
   end

   assign hw_standby_entry = hw_standby && !hw_standby_d_ff;
   assign soft_init        = sw_standby_entry || watch_entry || hw_standby;

   // =====================================================================
   // fault flag
   assign fault_raise = flash_fault_event;
   assign fault_clear = hw_standby_entry;

   always @* begin
      nxt_fault = fault_ff;
      if (fault_clear) begin
         nxt_fault = 1'b0;
      end
      if (fault_raise) begin
         nxt_fault = 1'b1;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         fault_ff <= 1'b0;
      end else begin
         fault_ff <= nxt_fault;
      end
   end

   assign error_protect = fault_ff;

   // =====================================================================
   // download request gating
   assign wr_ctrl     = wr_hit(reg_wr, reg_addr, `FCCTL_ADDR_CTRL);
   assign wr_irq_en   = wr_hit(reg_wr, reg_addr, `FCCTL_ADDR_IRQ_EN);
   assign wr_irq_clr  = wr_hit(reg_wr, reg_addr, `FCCTL_ADDR_IRQ_CLR);
   assign req_write   = wr_ctrl && reg_wdata[`FCCTL_BIT_REQ];
   assign gate_ok     = gates_met(unlock_key_register, exec_from_ram,
                                  ram_emulation_select);
   assign routine_ok  = program_routine_select || erase_routine_select;
   assign sel_erase   = erase_pick(program_routine_select, erase_routine_select);
   assign engine_free = !copy_busy;
   assign mode_idle   = !soft_init;
   assign dl_start    = req_write && gate_ok && routine_ok && engine_free
                        && mode_idle;
   assign dl_refused  = req_write && !dl_start;

   // =====================================================================
   // routine copy engine
   fcctl_copy u_copy (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .start         (dl_start),
      .abort         (soft_init),
      .sel_erase     (sel_erase),
      .dest          (download_destination),
      .busy          (copy_busy),
      .done          (copy_done),
      .rom_rd        (rom_rd),
      .rom_sel_erase (rom_sel_erase),
      .rom_addr      (rom_addr),
      .rom_data      (rom_data),
      .ram_wr        (ram_wr),
      .ram_addr      (ram_addr),
      .ram_wdata     (ram_wdata)
   );

   assign download_busy = copy_busy;
   assign download_done = copy_done;

   // =====================================================================
   // interrupt status, enable and clear
   assign ev_fault  = fault_raise && !fault_ff;
   assign ev_done   = copy_done;
   assign ev_refuse = dl_refused;

   always @* begin
      irq_set                    = `FCCTL_IRQ_RST;
      irq_set[`FCCTL_IRQ_FAULT]  = ev_fault;
      irq_set[`FCCTL_IRQ_DONE]   = ev_done;
      irq_set[`FCCTL_IRQ_REFUSE] = ev_refuse;
      irq_clr                    = `FCCTL_IRQ_RST;
      if (wr_irq_clr) begin
         irq_clr = reg_wdata[`FCCTL_IRQ_W-1:0];
      end
      nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
   end

   // sticky status
   always @(posedge core_clk) begin
      if (sys_rst) begin
         irq_stat_ff <= `FCCTL_IRQ_RST;
      end else if (soft_init) begin
         irq_stat_ff <= irq_set;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // enable
   always @(posedge core_clk) begin
      if (sys_rst) begin
         irq_en_ff <= `FCCTL_IRQ_RST;
      end else if (soft_init) begin
         irq_en_ff <= `FCCTL_IRQ_RST;
      end else if (wr_irq_en) begin
         irq_en_ff <= reg_wdata[`FCCTL_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_ff & irq_en_ff);

   // =====================================================================
   // register images
   assign key_ok       = (unlock_key_register == `FCCTL_UNLOCK_KEY);
   assign ctrl_img     = ctrl_image(fault_ff);
   assign irq_stat_img = pad_irq(irq_stat_ff);
   assign irq_en_img   = pad_irq(irq_en_ff);
   assign dl_stat_img  = dl_image(copy_busy, key_ok, exec_from_ram,
                                  ram_emulation_select, rom_sel_erase);

   // =====================================================================
   // read data, valid only in the cycle after the read strobe
   always @* begin
      nxt_rdata = `FCCTL_BYTE_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            `FCCTL_ADDR_CTRL: begin
               nxt_rdata = ctrl_img;
            end
            `FCCTL_ADDR_IRQ_STAT: begin
               nxt_rdata = irq_stat_img;
            end
            `FCCTL_ADDR_IRQ_EN: begin
               nxt_rdata = irq_en_img;
            end
            `FCCTL_ADDR_DL_STAT: begin
               nxt_rdata = dl_stat_img;
            end
            default: begin
               nxt_rdata = `FCCTL_BYTE_ZERO;
            end
         endcase
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_ff <= `FCCTL_BYTE_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule // fcctl_top

// >>> shared/fcctl_defines.vh
// Purpose: constants of the flash code control and status block
// Assumes: byte-wide register port, 100 MHz core_clk
// Notes:   offsets are byte addresses on the local register port
`ifndef FCCTL_DEFINES_VH
`define FCCTL_DEFINES_VH

// =====================================================================
// register offsets
`define FCCTL_ADDR_CTRL      8'h00
`define FCCTL_ADDR_IRQ_STAT  8'h01
`define FCCTL_ADDR_IRQ_EN    8'h02
`define FCCTL_ADDR_IRQ_CLR   8'h03
`define FCCTL_ADDR_DL_STAT   8'h04

// =====================================================================
// control register fields
`define FCCTL_BIT_ONE        7
`define FCCTL_BIT_FAULT      4
`define FCCTL_BIT_REQ        0
`define FCCTL_CTRL_FIXED     8'h80

// =====================================================================
// interrupt status fields
`define FCCTL_IRQ_W          3
`define FCCTL_IRQ_FAULT      0
`define FCCTL_IRQ_DONE       1
`define FCCTL_IRQ_REFUSE     2
`define FCCTL_IRQ_RST        3'h0

// =====================================================================
// download status fields
`define FCCTL_DL_BUSY        0
`define FCCTL_DL_KEY_OK      1
`define FCCTL_DL_IN_RAM      2
`define FCCTL_DL_NO_EMUL     3
`define FCCTL_DL_ERASE       4

// =====================================================================
// values
`define FCCTL_UNLOCK_KEY     8'ha5
`define FCCTL_ROUTINE_LAST   8'hff
`define FCCTL_BYTE_ZERO      8'h00
`define FCCTL_WORD_ZERO      16'h0000

`endif

// >>> tb/fcctl_checker.sv
// Purpose: port checker for fcctl_top
// Assumes: one clock domain, sys_rst synchronous
// Notes:   bound to every fcctl_top instance
`timescale 1ns/1ps

module fcctl_checker (
   // clock and reset
   input wire        core_clk,
   input wire        sys_rst,
   // register port
   input wire [7:0]  reg_addr,
   input wire [7:0]  reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata,
   // mode and gate inputs
   input wire        flash_fault_event,
   input wire        hw_standby_pin,
   input wire        sw_standby_entry,
   input wire        watch_entry,
   input wire [7:0]  unlock_key_register,
   input wire        program_routine_select,
   input wire        erase_routine_select,
   input wire [7:0]  download_destination,
   input wire        ram_emulation_select,
   input wire        exec_from_ram,
   // outputs
   input wire        rom_rd,
   input wire [7:0]  rom_addr,
   input wire        ram_wr,
   input wire [15:0] ram_addr,
   input wire        error_protect,
   input wire        download_busy,
   input wire        download_done
);
   // ====================
   // helpers
   reg  [3:0] hw_low_ff;
   wire       req_wr;
   wire       gate_ok;
   assign req_wr  = reg_wr && reg_addr == 8'h00 && reg_wdata[0];
   assign gate_ok = unlock_key_register == 8'ha5 && exec_from_ram && !ram_emulation_select;
   always @(posedge core_clk) begin
      if (sys_rst || hw_standby_pin)
         hw_low_ff <= 4'h0;
      else if (hw_low_ff != 4'hf)
         hw_low_ff <= hw_low_ff + 4'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ====================
   // properties
   fault_set_a: assert property (flash_fault_event |=> error_protect)
      else $error("fault flag not set");
   fault_quiet_a: assert property (!error_protect && !flash_fault_event |=> !error_protect)
      else $error("fault flag rose without fault");
   fault_keep_a: assert property (error_protect && hw_low_ff > 4'h6 |=> error_protect)
      else $error("fault flag lost");
   ctrl_read_a: assert property (reg_rd && reg_addr == 8'h00 |=>
      reg_rdata[3:0] == 4'h0 && reg_rdata[4] == $past(error_protect))
      else $error("control read wrong");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   gate_deny_a: assert property (req_wr && !gate_ok && !download_busy |=> !download_busy)
      else $error("download started without gate");
   dl_start_a: assert property (req_wr && gate_ok && !download_busy &&
      hw_low_ff > 4'h6 && (program_routine_select || erase_routine_select) &&
      !sw_standby_entry && !watch_entry
      |=> download_busy && rom_rd && rom_addr == 8'h00)
      else $error("download not started");
   dl_done_a: assert property ($rose(download_busy) |-> ##257 download_done)
      else $error("download done late");
   ram_dest_a: assert property (ram_wr |-> ram_addr[15:8] == download_destination)
      else $error("ram write outside destination");
endmodule // fcctl_checker

bind fcctl_top fcctl_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .flash_fault_event(flash_fault_event),
   .hw_standby_pin(hw_standby_pin), .sw_standby_entry(sw_standby_entry),
   .watch_entry(watch_entry), .unlock_key_register(unlock_key_register),
   .program_routine_select(program_routine_select),
   .erase_routine_select(erase_routine_select), .download_destination(download_destination),
   .ram_emulation_select(ram_emulation_select), .exec_from_ram(exec_from_ram),
   .rom_rd(rom_rd), .rom_addr(rom_addr), .ram_wr(ram_wr), .ram_addr(ram_addr),
   .error_protect(error_protect), .download_busy(download_busy),
   .download_done(download_done));

// >>> tb/fcctl_top_test.sv
// Purpose: self-checking bench for fcctl_top
// Assumes: 100 MHz core_clk, synchronous reset
// Notes:   rom word n holds {~n, n}
`timescale 1ns/1ps

module fcctl_top_test;
   // ====================
   // signals
   reg         clk;
   reg         rst;
   reg         wr;
   reg         rd;
   reg         flt;
   reg         hws;
   reg         sws;
   reg         wat;
   reg         psel;
   reg         esel;
   reg         emul;
   reg         inram;
   reg  [7:0]  addr;
   reg  [7:0]  wdat;
   reg  [7:0]  key;
   reg  [7:0]  dest;
   reg  [15:0] rom_data;
   wire [7:0]  rdat;
   wire [7:0]  rom_addr;
   wire [15:0] ram_addr;
   wire [15:0] ram_wdata;
   wire        rom_rd;
   wire        rom_sel;
   wire        ram_wr;
   wire        prot;
   wire        busy;
   wire        done;
   wire        irq;
   integer     errors;
   integer     checks;

   fcctl_top dut (.core_clk(clk), .sys_rst(rst), .reg_addr(addr), .reg_wdata(wdat),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .flash_fault_event(flt),
      .hw_standby_pin(hws), .sw_standby_entry(sws), .watch_entry(wat),
      .unlock_key_register(key), .program_routine_select(psel),
      .erase_routine_select(esel), .download_destination(dest),
      .ram_emulation_select(emul), .exec_from_ram(inram), .rom_rd(rom_rd),
      .rom_sel_erase(rom_sel), .rom_addr(rom_addr), .rom_data(rom_data), .ram_wr(ram_wr),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .error_protect(prot),
      .download_busy(busy), .download_done(done), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) rom_data <= {~rom_addr, rom_addr};

   // ====================
   // shared tasks
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wreg(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdat <= d;
         wr   <= 1'b1;
         @(posedge clk);
         wr   <= 1'b0;
      end
   endtask
   task rreg(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd   <= 1'b1;
         @(posedge clk);
         rd   <= 1'b0;
         #1;
         d = rdat;
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask

   // ====================
   // scenarios
   task t_reset;
      reg [7:0] v;
      begin
         rreg(8'h00, v);
         chk(v, 8'h80);
         chk(prot, 1'b0);
         rreg(8'hff, v);
         chk(v, 8'h00);
         rreg(8'h01, v);
         chk(v, 8'h00);
      end
   endtask
   task t_refuse;
      reg [7:0] v;
      integer   i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            key   <= (i == 0) ? 8'h5a : 8'ha5;
            inram <= (i != 1);
            emul  <= (i == 2);
            psel  <= (i != 3);
            wreg(8'h00, 8'h81);
            cyc(3);
            chk(busy, 1'b0);
            chk(rom_rd, 1'b0);
            rreg(8'h00, v);
            chk(v, 8'h80);
            rreg(8'h01, v);
            chk(v[2], 1'b1);
            wreg(8'h03, 8'h07);
         end
      end
   endtask
   task t_dl(input er);
      reg [7:0] v;
      reg [8:0] idx;
      integer   n;
      integer   at;
      begin
         key   <= 8'ha5;
         inram <= 1'b1;
         emul  <= 1'b0;
         psel  <= !er;
         esel  <= er;
         dest  <= er ? 8'hc3 : 8'h3c;
         wreg(8'h02, 8'h02);
         wreg(8'h00, 8'h81);
         idx = 9'h000;
         at  = 0;
         for (n = 1; n <= 262; n = n + 1) begin
            cyc(1);
            if (ram_wr) begin
               chk(ram_addr, {dest, idx[7:0]});
               chk(ram_wdata, {~idx[7:0], idx[7:0]});
               idx = idx + 9'h001;
            end
            if (done)
               at = n;
         end
         chk(idx, 9'h100);
         chk(at, 257);
         chk(rom_sel, er);
         rreg(8'h04, v);
         chk(v, {3'h0, er, 4'he});
         chk(irq, 1'b1);
         wreg(8'h03, 8'h02);
         cyc(1);
         chk(irq, 1'b0);
         rreg(8'h00, v);
         chk(v, 8'h80);
      end
   endtask
   task t_fault;
      reg [7:0] v;
      integer   n;
      begin
         wreg(8'h02, 8'h01);
         @(posedge clk);
         flt <= 1'b1;
         @(posedge clk);
         flt <= 1'b0;
         #1;
         chk(prot, 1'b1);
         chk(irq, 1'b1);
         wreg(8'h00, 8'h80);
         rreg(8'h00, v);
         chk(v, 8'h90);
         wreg(8'h02, 8'h00);
         cyc(1);
         chk(irq, 1'b0);
         wreg(8'h03, 8'h01);
         rreg(8'h01, v);
         chk(v[0], 1'b0);
         sws <= 1'b1;
         @(posedge clk);
         sws <= 1'b0;
         wat <= 1'b1;
         @(posedge clk);
         wat <= 1'b0;
         cyc(3);
         chk(prot, 1'b1);
         hws <= 1'b1;
         for (n = 0; n < 8 && prot; n = n + 1)
            cyc(1);
         chk(prot, 1'b0);
         hws <= 1'b0;
         cyc(8);
         flt <= 1'b1;
         @(posedge clk);
         flt <= 1'b0;
         rst <= 1'b1;
         cyc(10000);
         rst <= 1'b0;
         cyc(1);
         chk(prot, 1'b0);
         rreg(8'h00, v);
         chk(v, 8'h80);
      end
   endtask

   // ====================
   // main sequence and watchdog
   initial begin
      {rst, wr, rd, flt, hws, sws, wat, psel, esel, emul, inram} = 11'h400;
      {addr, wdat, key, dest} = 32'h0;
      errors   = 0;
      checks   = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_refuse;
      t_dl(1'b0);
      t_dl(1'b1);
      t_fault;
      wrap_up;
   end
   initial begin
      repeat (15000) @(posedge clk);
      errors = errors + 1;
      wrap_up;
   end
endmodule // fcctl_top_test
